//--- rtl/axil_port.sv
// AXI4-Lite slave front end: one write and one read in flight at most
// assumes the register file answers wr_err, rd_data, rd_err combinationally
`timescale 1ns/1ps
module axil_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_hold_q;
  logic w_hold_q;
  logic rd_pend_q;

  localparam logic [1:0] RESP_OKAY_L = sysctl_pkg::RESP_OKAY;

  // address and data are taken in either order, then written together
  assign wr_en = aw_hold_q & w_hold_q & ~bvalid;
  assign rd_en = rd_pend_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      awready <= 1'b1;
      wr_addr <= 12'h000;
    end else if (awvalid && awready) begin
      aw_hold_q <= 1'b1;
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else if (wr_en) begin
      aw_hold_q <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_hold_q <= 1'b0;
      wready <= 1'b1;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_hold_q <= 1'b1;
      wready <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_hold_q <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY_L;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_err ? sysctl_pkg::RESP_SLVERR : sysctl_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_addr <= 12'h000;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY_L;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rd_pend_q <= 1'b1;
      rd_addr <= araddr;
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_err ? sysctl_pkg::RESP_SLVERR : sysctl_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

//--- rtl/deep_sleep_gating_and_soft_reset.sv
// deep-sleep port clock gating and first soft reset register, AXI4-Lite
// assumes mode, run/sleep gating, auto select and capabilities come from
// neighbouring system control logic on the same clock
`timescale 1ns/1ps
module deep_sleep_gating_and_soft_reset (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  input wire logic auto_gating_select,
  input wire logic [4:0] run_clock_gate_2,
  input wire logic [4:0] sleep_clock_gate_2,
  input wire logic [31:0] capabilities_one,
  input wire logic [4:0] unit_access,
  output logic [4:0] port_clk_en_q,
  output sysctl_pkg::unit_reset_t unit_reset_q,
  output logic bus_fault_q,
  output logic irq_q
);
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic [31:0] byte_mask;
  logic [4:0] dscg_q;
  logic [1:0] ev_status_q;
  logic [1:0] ev_mask_q;
  logic [1:0] ev_set;
  logic [4:0] fault_bit;
  logic srst_sel;
  logic [31:0] srst_word;
  logic cap_drop;
  logic seen_q;
  sysctl_pkg::power_mode_t pm_q;

  axil_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // power mode tracker; deep-sleep wins if both requests are high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_q <= sysctl_pkg::PM_RUN;
    end else begin
      case (pm_q)
        sysctl_pkg::PM_RUN,
        sysctl_pkg::PM_SLEEP,
        sysctl_pkg::PM_DEEP: begin
          if (deep_sleep_mode) begin
            pm_q <= sysctl_pkg::PM_DEEP;
          end else if (sleep_mode) begin
            pm_q <= sysctl_pkg::PM_SLEEP;
          end else begin
            pm_q <= sysctl_pkg::PM_RUN;
          end
        end
        default: pm_q <= sysctl_pkg::PM_RUN;
      endcase
    end
  end

  gate_select u_sel (
    .clk(clk),
    .rst_n(rst_n),
    .mode(pm_q),
    .auto_gating_select(auto_gating_select),
    .run_gate(run_clock_gate_2),
    .sleep_gate(sleep_clock_gate_2),
    .deep_gate(dscg_q),
    .gate_q(port_clk_en_q)
  );

  assign byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                      {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // only bits 4..0 exist, so only byte lane 0 matters here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dscg_q <= sysctl_pkg::DSCG_RESET;
    end else if (wr_en && wr_addr == sysctl_pkg::DEEP_SLEEP_CLOCK_GATE_2_OFF
                 && wr_strb[0]) begin
      dscg_q <= wr_data[4:0];
    end
  end

  assign srst_sel = wr_en && wr_addr == sysctl_pkg::SOFT_RESET_CTRL_0_OFF;
  assign srst_word = wr_data & byte_mask;

  // absent capability keeps the old bit, which can be one if written while the capability was present
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_reset_q <= sysctl_pkg::SRST_RESET;
    end else if (srst_sel) begin
      if (capabilities_one[sysctl_pkg::PWM_BIT]
          && byte_mask[sysctl_pkg::PWM_BIT]) begin
        unit_reset_q.pwm_reset <= srst_word[sysctl_pkg::PWM_BIT];
      end
      if (capabilities_one[sysctl_pkg::ADC_BIT]
          && byte_mask[sysctl_pkg::ADC_BIT]) begin
        unit_reset_q.adc_reset <= srst_word[sysctl_pkg::ADC_BIT];
      end
      if (capabilities_one[sysctl_pkg::WATCHDOG_BIT]
          && byte_mask[sysctl_pkg::WATCHDOG_BIT]) begin
        unit_reset_q.watchdog_reset_ctl <=
          srst_word[sysctl_pkg::WATCHDOG_BIT];
      end
    end
  end

  // a write that tried to set a bit the capabilities mask away
  assign cap_drop = srst_sel && ((srst_word[sysctl_pkg::PWM_BIT]
                    && !capabilities_one[sysctl_pkg::PWM_BIT])
                    || (srst_word[sysctl_pkg::ADC_BIT]
                    && !capabilities_one[sysctl_pkg::ADC_BIT])
                    || (srst_word[sysctl_pkg::WATCHDOG_BIT]
                    && !capabilities_one[sysctl_pkg::WATCHDOG_BIT]));

  genvar gi;
  generate
    for (gi = 0; gi < sysctl_pkg::PORT_N; gi++) begin : g_fault
      assign fault_bit[gi] = unit_access[gi] & ~port_clk_en_q[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_fault_q <= 1'b0;
    end else begin
      bus_fault_q <= |fault_bit;
    end
  end

  always_comb begin
    ev_set = sysctl_pkg::EV_RESET;
    ev_set[sysctl_pkg::EV_GATE_FAULT] = |fault_bit;
    ev_set[sysctl_pkg::EV_CAP_DROP] = cap_drop;
  end

  // read clears the status, but a new event in that cycle still lands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_status_q <= sysctl_pkg::EV_RESET;
    end else if (rd_en && rd_addr == sysctl_pkg::EVENT_STATUS_OFF) begin
      ev_status_q <= ev_set;
    end else begin
      ev_status_q <= ev_status_q | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_mask_q <= sysctl_pkg::EV_RESET;
    end else if (wr_en && wr_addr == sysctl_pkg::EVENT_MASK_OFF && wr_strb[0]) begin
      ev_mask_q <= wr_data[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev_status_q & ev_mask_q);
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (rd_addr)
      sysctl_pkg::DEEP_SLEEP_CLOCK_GATE_2_OFF: rd_data[4:0] = dscg_q;
      sysctl_pkg::SOFT_RESET_CTRL_0_OFF: begin
        rd_data[sysctl_pkg::PWM_BIT] = unit_reset_q.pwm_reset;
        rd_data[sysctl_pkg::ADC_BIT] = unit_reset_q.adc_reset;
        rd_data[sysctl_pkg::WATCHDOG_BIT] = unit_reset_q.watchdog_reset_ctl;
      end
      sysctl_pkg::EVENT_STATUS_OFF: rd_data[1:0] = ev_status_q;
      sysctl_pkg::EVENT_MASK_OFF: rd_data[1:0] = ev_mask_q;
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    case (wr_addr)
      sysctl_pkg::DEEP_SLEEP_CLOCK_GATE_2_OFF,
      sysctl_pkg::SOFT_RESET_CTRL_0_OFF,
      sysctl_pkg::EVENT_STATUS_OFF,
      sysctl_pkg::EVENT_MASK_OFF: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  // marks the first cycle after reset release for the checks below
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  a_reset_clear_state: assert property (@(posedge clk) disable iff (!rst_n)
    !seen_q |-> dscg_q == 5'h00 && unit_reset_q == sysctl_pkg::SRST_RESET)
    else $error("gating or soft reset not zero after reset");

  a_deep_gate_used: assert property (@(posedge clk) disable iff (!rst_n)
    pm_q == sysctl_pkg::PM_DEEP && auto_gating_select
    |=> port_clk_en_q == $past(dscg_q))
    else $error("deep-sleep gating not applied in deep-sleep");

  a_run_gate_default: assert property (@(posedge clk) disable iff (!rst_n)
    !auto_gating_select |=> port_clk_en_q == $past(run_clock_gate_2))
    else $error("run gating not applied without auto select");

  a_gated_fault: assert property (@(posedge clk) disable iff (!rst_n)
    (|(unit_access & ~port_clk_en_q)) |=> bus_fault_q
    && ev_status_q[sysctl_pkg::EV_GATE_FAULT])
    else $error("access to stopped port gave no fault");

  a_open_no_fault: assert property (@(posedge clk) disable iff (!rst_n)
    !(|(unit_access & ~port_clk_en_q)) |=> !bus_fault_q)
    else $error("fault raised for a clocked port");

  a_gate_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && rd_addr == sysctl_pkg::DEEP_SLEEP_CLOCK_GATE_2_OFF
    |-> rd_data[31:5] == 27'h0000000 && rd_data[4:0] == dscg_q)
    else $error("gating read shows reserved bits");

  a_gate_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && wr_addr == sysctl_pkg::DEEP_SLEEP_CLOCK_GATE_2_OFF && wr_strb[0]
    |=> dscg_q == $past(wr_data[4:0]))
    else $error("gating write lost");

  a_cap_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
    srst_sel && !capabilities_one[sysctl_pkg::PWM_BIT]
    |=> $stable(unit_reset_q.pwm_reset))
    else $error("soft reset bit written without capability");

  a_srst_write: assert property (@(posedge clk) disable iff (!rst_n)
    srst_sel && wr_strb == 4'hF && (&capabilities_one)
    |=> unit_reset_q == {$past(wr_data[20]), $past(wr_data[16]), $past(wr_data[3])})
    else $error("soft reset write not applied");

  a_reset_held: assert property (@(posedge clk) disable iff (!rst_n)
    unit_reset_q.pwm_reset && !srst_sel |=> unit_reset_q.pwm_reset)
    else $error("unit left reset without a write");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    (|(ev_status_q & ev_mask_q)) |=> irq_q)
    else $error("interrupt not raised for unmasked event");

  c_deep_mode: cover property (@(posedge clk) disable iff (!rst_n)
    pm_q == sysctl_pkg::PM_DEEP && auto_gating_select);
  c_bus_fault: cover property (@(posedge clk) disable iff (!rst_n) bus_fault_q);
  c_srst_set: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(unit_reset_q.watchdog_reset_ctl));
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_q));
endmodule

//--- rtl/gate_select.sv
// picks the live port clock enables from the mode-specific gating sets
// assumes mode and all gating sets are on the same clock
`timescale 1ns/1ps
module gate_select (
  input wire logic clk,
  input wire logic rst_n,
  input sysctl_pkg::power_mode_t mode,
  input wire logic auto_gating_select,
  input wire logic [4:0] run_gate,
  input wire logic [4:0] sleep_gate,
  input wire logic [4:0] deep_gate,
  output logic [4:0] gate_q
);
  logic [4:0] gate_d;

  always_comb begin
    gate_d = run_gate;
    if (auto_gating_select) begin
      case (mode)
        sysctl_pkg::PM_SLEEP: gate_d = sleep_gate;
        sysctl_pkg::PM_DEEP: gate_d = deep_gate;
        default: gate_d = run_gate;
      endcase
    end
  end

  // registered so the enables never glitch on a mode change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= sysctl_pkg::DSCG_RESET;
    end else begin
      gate_q <= gate_d;
    end
  end
endmodule

//--- rtl/sysctl_pkg.sv
// shared constants and types for the deep-sleep gating / soft reset block
// assumes one 20 MHz clock and an AXI4-Lite master on the register side
package sysctl_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PORT_N = 5;
  localparam int unsigned EV_N = 2;
  localparam logic [11:0] SOFT_RESET_CTRL_0_OFF = 12'h040;
  localparam logic [11:0] DEEP_SLEEP_CLOCK_GATE_2_OFF = 12'h128;
  localparam logic [11:0] EVENT_STATUS_OFF = 12'h200;
  localparam logic [11:0] EVENT_MASK_OFF = 12'h204;
  localparam logic [4:0] DSCG_RESET = 5'h00;
  localparam logic [1:0] EV_RESET = 2'h0;
  localparam int unsigned PORT_A_GATE = 0;
  localparam int unsigned PORT_B_GATE = 1;
  localparam int unsigned PORT_C_GATE = 2;
  localparam int unsigned PORT_D_GATE = 3;
  localparam int unsigned PORT_E_GATE = 4;
  localparam int unsigned PWM_BIT = 20;
  localparam int unsigned ADC_BIT = 16;
  localparam int unsigned WATCHDOG_BIT = 3;
  localparam int unsigned EV_GATE_FAULT = 0;
  localparam int unsigned EV_CAP_DROP = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    PM_RUN = 3'h1,
    PM_SLEEP = 3'h2,
    PM_DEEP = 3'h4
  } power_mode_t;
  typedef struct packed {
    logic pwm_reset;
    logic adc_reset;
    logic watchdog_reset_ctl;
  } unit_reset_t;
  localparam unit_reset_t SRST_RESET = unit_reset_t'(3'h0);
endpackage

//--- tb/tb_deep_sleep_gating_and_soft_reset.sv
// self-checking bench for the deep-sleep gating and soft reset block
// assumes the block answers over AXI4-Lite and sees one 20 MHz clock
`timescale 1ns/1ps
module tb_deep_sleep_gating_and_soft_reset;
  localparam logic [31:0] SRM = 32'h0011_0008;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, capabilities_one = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, bus_fault_q, irq_q;
  logic [1:0] bresp, rresp;
  logic sleep_mode = 1'b0, deep_sleep_mode = 1'b0, auto_gating_select = 1'b0;
  logic [4:0] run_clock_gate_2 = 5'h00, sleep_clock_gate_2 = 5'h00, unit_access = 5'h00;
  logic [4:0] port_clk_en_q;
  sysctl_pkg::unit_reset_t unit_reset_q;
  logic [31:0] m_dscg = 32'h0, m_srst = 32'h0, m_stat = 32'h0, m_mask = 32'h0;
  int err_total = 0;
  int checks_done = 0;
  int seed = 4503;
  int i;

  always #25 clk = ~clk;

  deep_sleep_gating_and_soft_reset dut (.clk(clk), .rst_n(rst_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
    .auto_gating_select(auto_gating_select), .run_clock_gate_2(run_clock_gate_2),
    .sleep_clock_gate_2(sleep_clock_gate_2), .capabilities_one(capabilities_one),
    .unit_access(unit_access), .port_clk_en_q(port_clk_en_q), .unit_reset_q(unit_reset_q),
    .bus_fault_q(bus_fault_q), .irq_q(irq_q));

  task give_verdict;
    $display("counts: %0d checks, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task hung;
    err_total++;
    $display("[ERR] handshake expected 1 seen none");
    give_verdict();
  endtask

  function automatic logic [4:0] exp_en();
    if (auto_gating_select && deep_sleep_mode) return m_dscg[4:0];
    if (auto_gating_select && sleep_mode) return sleep_clock_gate_2;
    return run_clock_gate_2;
  endfunction

  // model of a write, lanes and capability mask applied
  task m_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] be;
    logic [31:0] wm;
    be = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    wm = be & capabilities_one & SRM;
    if (a == 12'h128) m_dscg = ((m_dscg & ~be) | (d & be)) & 32'h1F;
    if (a == 12'h204) m_mask = ((m_mask & ~be) | (d & be)) & 32'h3;
    if (a == 12'h040) begin
      m_srst = (m_srst & ~wm) | (d & wm);
      if ((d & be & ~capabilities_one & SRM) != 32'h0) m_stat = m_stat | 32'h2;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] er;
    bit ok;
    ok = 1'b0;
    er = (a == 12'h040 || a == 12'h128 || a == 12'h200 || a == 12'h204) ?
      sysctl_pkg::RESP_OKAY : sysctl_pkg::RESP_SLVERR;
    @(posedge clk);
    // after the edge, so a capability change made just before the call counts
    m_write(a, d, s);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        ok = 1'b1;
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
      end
    end
    if (!ok) hung();
  endtask

  task rd(input logic [11:0] a);
    logic [31:0] e;
    logic [1:0] er;
    bit ok;
    ok = 1'b0;
    e = 32'h0;
    er = sysctl_pkg::RESP_OKAY;
    case (a)
      sysctl_pkg::SOFT_RESET_CTRL_0_OFF: e = m_srst;
      sysctl_pkg::DEEP_SLEEP_CLOCK_GATE_2_OFF: e = m_dscg;
      sysctl_pkg::EVENT_STATUS_OFF: begin
        e = m_stat;
        m_stat = 32'h0;
      end
      sysctl_pkg::EVENT_MASK_OFF: e = m_mask;
      default: er = sysctl_pkg::RESP_SLVERR;
    endcase
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        rready <= 1'b0;
        check("rdata", rdata, e);
        check("rresp", {30'h0, rresp}, {30'h0, er});
      end
    end
    if (!ok) hung();
  endtask

  task set_in(input logic a, input logic s, input logic d, input logic [4:0] rg,
              input logic [4:0] sg);
    @(posedge clk);
    auto_gating_select <= a;
    sleep_mode <= s;
    deep_sleep_mode <= d;
    run_clock_gate_2 <= rg;
    sleep_clock_gate_2 <= sg;
  endtask

  // mode input to enable takes two edges, three leaves margin
  task outs_chk;
    repeat (3) @(posedge clk);
    #1;
    check("port_clk_en", {27'h0, port_clk_en_q}, {27'h0, exp_en()});
    check("unit_reset", {29'h0, unit_reset_q},
          {29'h0, m_srst[20], m_srst[16], m_srst[3]});
    check("irq", {31'h0, irq_q}, {31'h0, |(m_stat & m_mask)});
  endtask

  task fault(input int p);
    logic [4:0] en;
    en = exp_en();
    @(posedge clk);
    unit_access <= 5'h01 << p;
    @(posedge clk);
    unit_access <= 5'h00;
    #1;
    check("bus_fault", {31'h0, bus_fault_q}, {31'h0, ~en[p]});
    if (!en[p]) m_stat = m_stat | 32'h1;
    @(posedge clk);
    #1;
    check("bus_fault_end", {31'h0, bus_fault_q}, 32'h0);
    check("irq", {31'h0, irq_q}, {31'h0, |(m_stat & m_mask)});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    outs_chk();
    rd(12'h040);
    rd(12'h128);
    rd(12'h204);
    $display("test reset values done");
    wr(12'h128, 32'hFFFF_FFFF, 4'hF);
    rd(12'h128);
    wr(12'h128, 32'h0000_0000, 4'hE);
    rd(12'h128);
    set_in(1'b1, 1'b0, 1'b1, 5'h00, 5'h00);
    for (i = 0; i < 5; i++) begin
      wr(12'h128, 32'h1 << i, 4'h1);
      outs_chk();
    end
    for (i = 0; i < 8; i++) begin
      wr(12'h128, $random(seed), 4'h1);
      set_in(i[0], i[1], i[2], 5'($random(seed)), 5'($random(seed)));
      outs_chk();
    end
    $display("test gating modes done");
    set_in(1'b0, 1'b0, 1'b0, 5'h0A, 5'h15);
    wr(12'h204, 32'h1, 4'h1);
    outs_chk();
    for (i = 0; i < 5; i++) fault(i);
    rd(12'h200);
    rd(12'h200);
    outs_chk();
    wr(12'h204, 32'h0, 4'h1);
    fault(0);
    rd(12'h200);
    $display("test bus fault done");
    capabilities_one <= 32'hFFFF_FFFF;
    wr(12'h040, 32'hFFFF_FFFF, 4'hF);
    rd(12'h040);
    outs_chk();
    wr(12'h040, 32'h0, 4'hF);
    outs_chk();
    capabilities_one <= 32'hFFEF_FFFF;
    wr(12'h204, 32'h2, 4'h1);
    wr(12'h040, 32'h0010_0000, 4'hF);
    outs_chk();
    rd(12'h040);
    rd(12'h200);
    wr(12'h040, 32'h0001_0008, 4'h3);
    rd(12'h040);
    $display("test soft reset done");
    wr(12'h300, 32'h1234_5678, 4'hF);
    rd(12'h300);
    wr(12'h200, 32'hFFFF_FFFF, 4'hF);
    rd(12'h200);
    $display("test unmapped done");
    for (i = 0; i < 20; i++) begin
      capabilities_one <= $random(seed);
      wr(12'h040, $random(seed), 4'($random(seed)));
      rd(12'h040);
      wr(12'h128, $random(seed), 4'($random(seed)));
      rd(12'h128);
      outs_chk();
      rd(12'h200);
    end
    $display("test random writes done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    m_srst = 32'h0;
    m_dscg = 32'h0;
    m_stat = 32'h0;
    m_mask = 32'h0;
    outs_chk();
    rd(12'h040);
    rd(12'h128);
    $display("test second reset done");
    give_verdict();
  end
endmodule
